// File: core/spm_pkg.sv
// constants for the shared pin priority multiplexer and port registers
// assumes a byte-wide register port with a 4-bit direct page address
package spm_pkg;
	// register addresses
	localparam logic [3:0] ADDR_PORT_A_DATA = 4'h0;
	localparam logic [3:0] ADDR_PORT_B_DATA = 4'h1;
	localparam logic [3:0] ADDR_PORT_C_DATA = 4'h2;
	localparam logic [3:0] ADDR_PORT_D_DATA = 4'h3;
	localparam logic [3:0] ADDR_PORT_A_DIR  = 4'h4;
	localparam logic [3:0] ADDR_PORT_B_DIR  = 4'h5;
	localparam logic [3:0] ADDR_PORT_C_DIR  = 4'h6;
	localparam logic [3:0] ADDR_PORT_D_DIR  = 4'h7;
	localparam logic [3:0] ADDR_PORT_C_PULL = 4'h9;
	localparam logic [3:0] ADDR_PORT_D_PULL = 4'hA;
	localparam logic [3:0] ADDR_PORT_A_PULL = 4'hB;
	localparam logic [3:0] ADDR_PORT_B_PULL = 4'hC;
	// implemented bit masks
	localparam logic [7:0] MASK_A_DATA = 8'h3F;
	localparam logic [7:0] MASK_A_DIR  = 8'h3B;
	localparam logic [7:0] MASK_A_PULL = 8'hBF;
	localparam logic [7:0] MASK_C_DATA = 8'h0F;
	localparam logic [7:0] MASK_C_DIR  = 8'h07;
	localparam logic [7:0] MASK_C_PULL = 8'h0F;
	localparam logic [7:0] MASK_FULL   = 8'hFF;
	// field positions and reset values
	localparam int         OSC_OUT_ENABLE_BIT = 7;
	localparam logic [7:0] RESET_ZERO         = 8'h00;
endpackage

// File: core/spm_pin_mux.sv
// shared pin priority multiplexer with port a..d data, direction and pull-up registers
// the peripherals keep their own enables; this block only decides who owns each pad
// assumes pins are not synchronised elsewhere; this block synchronises them for register reads and peripherals;
// pin levels entering here pass two flip-flops before a register read and three before reaching the peripherals
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux (
	// clock, reset, enable
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       clk_en_in,
	// register port
	input  wire logic [3:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// pins: levels in, drive out, enable low while driving
	input  wire logic [5:0] pin_a_in,
	input  wire logic [7:0] pin_b_in,
	input  wire logic [3:0] pin_c_in,
	input  wire logic [7:0] pin_d_in,
	output logic      [5:0] pin_a_out,
	output logic      [7:0] pin_b_out,
	output logic      [3:0] pin_c_out,
	output logic      [7:0] pin_d_out,
	output logic      [5:0] pin_a_oen_out,
	output logic      [7:0] pin_b_oen_out,
	output logic      [3:0] pin_c_oen_out,
	output logic      [7:0] pin_d_oen_out,
	output logic      [5:0] pull_a_out,
	output logic      [7:0] pull_b_out,
	output logic      [3:0] pull_c_out,
	output logic      [7:0] pull_d_out,
	// peripheral enables (each function but analog claims the pin)
	input  wire logic [9:0] analog_sel_in,
	input  wire logic [1:0] timer1_ch_en_in,
	input  wire logic [1:0] timer1_hi_en_in,
	input  wire logic       timer1_ext_clock_en_in,
	input  wire logic [5:0] keypad_en_in,
	input  wire logic       irq_en_in,
	input  wire logic       reset_pin_en_in,
	input  wire logic       osc_in_en_in,
	input  wire logic       xtal_out_en_in,
	input  wire logic       spi_en_in,
	input  wire logic       spi_master_in,
	input  wire logic       serial_rx_en_in,
	input  wire logic       serial_tx_en_in,
	input  wire logic [1:0] timer2_ch_en_in,
	input  wire logic       timer2_ext_clock_en_in,
	input  wire logic       timer2_channel_relocate_in,
	// peripheral outputs and their drive requests
	input  wire logic [1:0] timer1_ch_out_in,
	input  wire logic [1:0] timer1_ch_drive_in,
	input  wire logic [1:0] timer1_hi_out_in,
	input  wire logic [1:0] timer1_hi_drive_in,
	input  wire logic       osc_clock_in,
	input  wire logic       spi_clock_out_in,
	input  wire logic       spi_mosi_out_in,
	input  wire logic       spi_miso_out_in,
	input  wire logic       serial_tx_out_in,
	input  wire logic [1:0] timer2_ch_out_in,
	input  wire logic [1:0] timer2_ch_drive_in,
	// synchronised pin levels to peripherals and analog
	output logic      [5:0] sync_a_out,
	output logic      [7:0] sync_b_out,
	output logic      [3:0] sync_c_out,
	output logic      [7:0] sync_d_out
);
	// =========================================================
	// registers
	// sync stages are named by port and stage number
	logic [7:0] data_a_r, data_b_r, data_c_r, data_d_r;
	logic [7:0] dir_a_r, dir_b_r, dir_c_r, dir_d_r;
	logic [7:0] pull_a_r, pull_b_r, pull_c_r, pull_d_r;
	logic [5:0] sa1_r, sa2_r;
	logic [7:0] sb1_r, sb2_r;
	logic [3:0] sc1_r, sc2_r;
	logic [7:0] sd1_r, sd2_r;
	logic       rst_seen_r;
	// next pin drive
	logic [5:0] a_nxt, a_oen_nxt, a_pu_nxt;
	logic [7:0] b_nxt, b_oen_nxt, b_pu_nxt;
	logic [3:0] c_nxt, c_oen_nxt, c_pu_nxt;
	logic [7:0] d_nxt, d_oen_nxt, d_pu_nxt;
	logic [7:0] rdata_nxt;
	logic       wr;

	assign wr = clk_en_in && reg_wr_in;

	// read value mixes latch and pin: output bits read latch, inputs read pin
	function automatic logic [7:0] port_read(input logic [7:0] dat, input logic [7:0] dir,
			input logic [7:0] pin, input logic [7:0] mask);
		port_read = ((dat & dir) | (pin & ~dir)) & mask;
	endfunction

	// =========================================================
	// pin synchronisers
	// the first stage may go metastable; only the second stage is read below
	always_ff @(posedge clk_in) begin
		if (clk_en_in) begin
			sa1_r <= pin_a_in;
			sa2_r <= sa1_r;
			sb1_r <= pin_b_in;
			sb2_r <= sb1_r;
			sc1_r <= pin_c_in;
			sc2_r <= sc1_r;
			sd1_r <= pin_d_in;
			sd2_r <= sd1_r;
		end
	end

	// =========================================================
	// data latches, not reset
	// software must write a latch before it sets the direction, or the pin drives garbage
	always_ff @(posedge clk_in) begin
		if (wr && reg_addr_in == spm_pkg::ADDR_PORT_A_DATA) begin
			data_a_r <= reg_wdata_in & spm_pkg::MASK_A_DATA;
		end
		if (wr && reg_addr_in == spm_pkg::ADDR_PORT_B_DATA) begin
			data_b_r <= reg_wdata_in;
		end
		if (wr && reg_addr_in == spm_pkg::ADDR_PORT_C_DATA) begin
			data_c_r <= reg_wdata_in & spm_pkg::MASK_C_DATA;
		end
		if (wr && reg_addr_in == spm_pkg::ADDR_PORT_D_DATA) begin
			data_d_r <= reg_wdata_in;
		end
	end

	// direction registers
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			dir_a_r <= spm_pkg::RESET_ZERO;
			dir_b_r <= spm_pkg::RESET_ZERO;
			dir_c_r <= spm_pkg::RESET_ZERO;
			dir_d_r <= spm_pkg::RESET_ZERO;
		end else if (wr) begin
			unique case (reg_addr_in)
				spm_pkg::ADDR_PORT_A_DIR: dir_a_r <= reg_wdata_in & spm_pkg::MASK_A_DIR;
				spm_pkg::ADDR_PORT_B_DIR: dir_b_r <= reg_wdata_in;
				spm_pkg::ADDR_PORT_C_DIR: dir_c_r <= reg_wdata_in & spm_pkg::MASK_C_DIR;
				spm_pkg::ADDR_PORT_D_DIR: dir_d_r <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// pull-up registers
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pull_a_r <= spm_pkg::RESET_ZERO;
			pull_b_r <= spm_pkg::RESET_ZERO;
			pull_c_r <= spm_pkg::RESET_ZERO;
			pull_d_r <= spm_pkg::RESET_ZERO;
		end else if (wr) begin
			unique case (reg_addr_in)
				spm_pkg::ADDR_PORT_A_PULL: pull_a_r <= reg_wdata_in & spm_pkg::MASK_A_PULL;
				spm_pkg::ADDR_PORT_B_PULL: pull_b_r <= reg_wdata_in;
				spm_pkg::ADDR_PORT_C_PULL: pull_c_r <= reg_wdata_in & spm_pkg::MASK_C_PULL;
				spm_pkg::ADDR_PORT_D_PULL: pull_d_r <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// holds all pins as inputs from reset until the first enabled cycle after it
	// this keeps a stale drive from reaching a pin on the release edge itself
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rst_seen_r <= 1'b0;
		end else if (clk_en_in) begin
			rst_seen_r <= 1'b1;
		end
	end

	// =========================================================
	// read mux
	// input bits read the second sync stage, so a pin change shows two cycles late
	always_comb begin
		unique case (reg_addr_in)
			spm_pkg::ADDR_PORT_A_DATA: rdata_nxt = port_read(data_a_r, dir_a_r, {2'b00, sa2_r}, spm_pkg::MASK_A_DATA);
			spm_pkg::ADDR_PORT_B_DATA: rdata_nxt = port_read(data_b_r, dir_b_r, sb2_r, spm_pkg::MASK_FULL);
			spm_pkg::ADDR_PORT_C_DATA: rdata_nxt = port_read(data_c_r, dir_c_r, {4'h0, sc2_r}, spm_pkg::MASK_C_DATA);
			spm_pkg::ADDR_PORT_D_DATA: rdata_nxt = port_read(data_d_r, dir_d_r, sd2_r, spm_pkg::MASK_FULL);
			spm_pkg::ADDR_PORT_A_DIR:  rdata_nxt = dir_a_r;
			spm_pkg::ADDR_PORT_B_DIR:  rdata_nxt = dir_b_r;
			spm_pkg::ADDR_PORT_C_DIR:  rdata_nxt = dir_c_r;
			spm_pkg::ADDR_PORT_D_DIR:  rdata_nxt = dir_d_r;
			spm_pkg::ADDR_PORT_A_PULL: rdata_nxt = pull_a_r;
			spm_pkg::ADDR_PORT_B_PULL: rdata_nxt = pull_b_r;
			spm_pkg::ADDR_PORT_C_PULL: rdata_nxt = pull_c_r;
			spm_pkg::ADDR_PORT_D_PULL: rdata_nxt = pull_d_r;
			default:                   rdata_nxt = 8'h00; // reserved slot and unmapped
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (clk_en_in && reg_rd_in) begin
			reg_rdata_out <= rdata_nxt;
		end
	end

	// =========================================================
	// priority resolution: first claim wins; analog never claims
	// each pin starts from its plain port setting and a claiming function overrides it
	always_comb begin
		// plain port defaults: drive only when direction is output
		a_nxt = data_a_r[5:0];
		a_oen_nxt = ~dir_a_r[5:0];
		b_nxt = data_b_r;
		b_oen_nxt = ~dir_b_r;
		c_nxt = data_c_r[3:0];
		c_oen_nxt = ~dir_c_r[3:0];
		d_nxt = data_d_r;
		d_oen_nxt = ~dir_d_r;
		// claimed pins keep a pull-up only for input-only claims other than the oscillator input
		a_pu_nxt = pull_a_r[5:0] & ~dir_a_r[5:0];
		b_pu_nxt = pull_b_r & ~dir_b_r;
		c_pu_nxt = pull_c_r[3:0] & ~dir_c_r[3:0];
		d_pu_nxt = pull_d_r & ~dir_d_r;
		// port a bits 0,1: analog only samples, timer1 then keypad
		for (int i = 0; i < 2; i++) begin
			if (timer1_ch_en_in[i]) begin
				a_nxt[i] = timer1_ch_out_in[i];
				a_oen_nxt[i] = ~timer1_ch_drive_in[i];
				a_pu_nxt[i] = 1'b0;
			end else if (keypad_en_in[i]) begin
				a_oen_nxt[i] = 1'b1;
			end
		end
		// port a bit 2: input only; all functions input
		a_oen_nxt[2] = 1'b1;
		if (irq_en_in || timer1_ext_clock_en_in || keypad_en_in[2]) begin
			a_pu_nxt[2] = pull_a_r[2];
		end
		// port a bit 3: reset input first, then keypad
		if (reset_pin_en_in || keypad_en_in[3]) begin
			a_oen_nxt[3] = 1'b1;
			a_pu_nxt[3] = pull_a_r[3];
		end
		// port a bit 4: oscillator output wins
		// the oscillator output also drops the pull-up so it never loads the clock
		if (pull_a_r[spm_pkg::OSC_OUT_ENABLE_BIT] || xtal_out_en_in) begin
			a_nxt[4] = osc_clock_in;
			a_oen_nxt[4] = 1'b0;
			a_pu_nxt[4] = 1'b0;
		end else if (keypad_en_in[4]) begin
			a_oen_nxt[4] = 1'b1;
			a_pu_nxt[4] = pull_a_r[4];
		end
		// port a bit 5: oscillator input wins
		if (osc_in_en_in) begin
			a_oen_nxt[5] = 1'b1;
			a_pu_nxt[5] = 1'b0;
		end else if (keypad_en_in[5]) begin
			a_oen_nxt[5] = 1'b1;
			a_pu_nxt[5] = pull_a_r[5];
		end
		// port b bit 0: spi clock
		if (spi_en_in) begin
			b_nxt[0] = spi_clock_out_in;
			b_oen_nxt[0] = ~spi_master_in;
			b_pu_nxt[0] = 1'b0;
		end
		// port b bits 1,2: spi data, then timer2 channel when not relocated
		if (spi_en_in) begin
			b_nxt[1] = spi_mosi_out_in;
			b_oen_nxt[1] = ~spi_master_in;
			b_nxt[2] = spi_miso_out_in;
			b_oen_nxt[2] = spi_master_in;
			b_pu_nxt[2:1] = 2'b00;
		end else if (!timer2_channel_relocate_in) begin
			if (timer2_ch_en_in[1]) begin
				b_nxt[1] = timer2_ch_out_in[1];
				b_oen_nxt[1] = ~timer2_ch_drive_in[1];
				b_pu_nxt[1] = 1'b0;
			end
			if (timer2_ch_en_in[0]) begin
				b_nxt[2] = timer2_ch_out_in[0];
				b_oen_nxt[2] = ~timer2_ch_drive_in[0];
				b_pu_nxt[2] = 1'b0;
			end
		end
		// port b bit 3: spi select, then timer2 clock, both inputs
		if (spi_en_in || timer2_ext_clock_en_in) begin
			b_oen_nxt[3] = 1'b1;
			b_pu_nxt[3] = pull_b_r[3];
		end
		// port b bit 4: serial rx, then relocated timer2 channel 0
		if (serial_rx_en_in) begin
			b_oen_nxt[4] = 1'b1;
			b_pu_nxt[4] = pull_b_r[4];
		end else if (timer2_channel_relocate_in && timer2_ch_en_in[0]) begin
			b_nxt[4] = timer2_ch_out_in[0];
			b_oen_nxt[4] = ~timer2_ch_drive_in[0];
			b_pu_nxt[4] = 1'b0;
		end
		// port b bit 5: serial tx, then relocated timer2 channel 1
		if (serial_tx_en_in) begin
			b_nxt[5] = serial_tx_out_in;
			b_oen_nxt[5] = 1'b0;
			b_pu_nxt[5] = 1'b0;
		end else if (timer2_channel_relocate_in && timer2_ch_en_in[1]) begin
			b_nxt[5] = timer2_ch_out_in[1];
			b_oen_nxt[5] = ~timer2_ch_drive_in[1];
			b_pu_nxt[5] = 1'b0;
		end
		// port b bits 6,7: timer1 channels 2,3
		for (int i = 0; i < 2; i++) begin
			if (timer1_hi_en_in[i]) begin
				b_nxt[6+i] = timer1_hi_out_in[i];
				b_oen_nxt[6+i] = ~timer1_hi_drive_in[i];
				b_pu_nxt[6+i] = 1'b0;
			end
		end
		// port c bit 3 is input only
		c_oen_nxt[3] = 1'b1;
		c_pu_nxt[3] = pull_c_r[3];
	end

	// =========================================================
	// pin output flip-flops; held as inputs through reset
	// every pin output comes from a flop, so no decode glitch reaches a pad
	always_ff @(posedge clk_in) begin
		if (!resetn_in || !rst_seen_r) begin
			pin_a_out <= 6'h00;
			pin_b_out <= 8'h00;
			pin_c_out <= 4'h0;
			pin_d_out <= 8'h00;
			pin_a_oen_out <= 6'h3F;
			pin_b_oen_out <= 8'hFF;
			pin_c_oen_out <= 4'hF;
			pin_d_oen_out <= 8'hFF;
			pull_a_out <= 6'h00;
			pull_b_out <= 8'h00;
			pull_c_out <= 4'h0;
			pull_d_out <= 8'h00;
		end else if (clk_en_in) begin
			pin_a_out <= a_nxt;
			pin_b_out <= b_nxt;
			pin_c_out <= c_nxt;
			pin_d_out <= d_nxt;
			pin_a_oen_out <= a_oen_nxt;
			pin_b_oen_out <= b_oen_nxt;
			pin_c_oen_out <= c_oen_nxt;
			pin_d_oen_out <= d_oen_nxt;
			pull_a_out <= a_pu_nxt & a_oen_nxt;
			pull_b_out <= b_pu_nxt & b_oen_nxt;
			pull_c_out <= c_pu_nxt & c_oen_nxt;
			pull_d_out <= d_pu_nxt & d_oen_nxt;
		end
	end

	// synchronised levels for peripherals; analog samples alongside all functions
	// a third flop here gives every peripheral the same settled copy
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sync_a_out <= 6'h00;
			sync_b_out <= 8'h00;
			sync_c_out <= 4'h0;
			sync_d_out <= 8'h00;
		end else if (clk_en_in) begin
			sync_a_out <= sa2_r;
			sync_b_out <= sb2_r;
			sync_c_out <= sc2_r;
			sync_d_out <= sd2_r;
		end
	end
endmodule
`default_nettype wire

// File: tb/spm_pin_mux_properties.sv
// ======================================
// checker on the pin multiplexer top ports
// assumes one clock domain and a synchronous low reset
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux_chk (
	// clock and register port
	input wire logic       clk_in,
	input wire logic       resetn_in,
	input wire logic       clk_en_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	// pin side
	input wire logic [5:0] pin_a_oen_out,
	input wire logic [3:0] pin_c_oen_out,
	input wire logic [7:0] pin_d_out,
	input wire logic [7:0] pin_d_oen_out,
	input wire logic [5:0] pull_a_out,
	input wire logic [3:0] pull_c_out,
	input wire logic [7:0] pull_d_out
);
	logic wr_ok;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	// accepted write strobe
	assign wr_ok = reg_wr_in & clk_en_in;
	// ======================================
	// properties
	chk_reset_idle: assert property (!$past(resetn_in) |->
		&{pin_a_oen_out, pin_c_oen_out, pin_d_oen_out} && !(|{pull_a_out, pull_d_out}))
		else $error("pins not inputs after reset");
	chk_input_only: assert property (pin_a_oen_out[2] && pin_c_oen_out[3])
		else $error("input-only pin driven");
	chk_pull_undriven: assert property (
		!(|{pull_a_out & ~pin_a_oen_out, pull_c_out & ~pin_c_oen_out, pull_d_out & ~pin_d_oen_out}))
		else $error("pull-up on a driven pin");
	chk_dir_drive: assert property ((wr_ok && reg_addr_in == 4'h7) ##1 clk_en_in
		|=> pin_d_oen_out == ~$past(reg_wdata_in, 2))
		else $error("direction write not on pins");
	chk_latch_drive: assert property ((wr_ok && reg_addr_in == 4'h3) ##1 clk_en_in
		|=> (pin_d_out & ~pin_d_oen_out) == ($past(reg_wdata_in, 2) & ~pin_d_oen_out))
		else $error("data latch not on driven pins");
	chk_pull_c: assert property ((wr_ok && reg_addr_in == 4'h9) ##1 clk_en_in
		|=> {4'h0, pull_c_out} == ($past(reg_wdata_in, 2) & {4'h0, pin_c_oen_out}))
		else $error("port c pull-up wrong");
	chk_osc_drive: assert property ((wr_ok && reg_addr_in == 4'hB && reg_wdata_in[7])
		##1 clk_en_in |=> !pin_a_oen_out[4])
		else $error("oscillator output not driven");
	chk_read_hold: assert property (!(reg_rd_in && clk_en_in) |=> $stable(reg_rdata_out))
		else $error("read data changed without read");
endmodule
bind spm_pin_mux spm_pin_mux_chk i_spm_pin_mux_chk (
	.clk_in, .resetn_in, .clk_en_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
	.reg_rdata_out, .pin_a_oen_out, .pin_c_oen_out, .pin_d_out, .pin_d_oen_out,
	.pull_a_out, .pull_c_out, .pull_d_out
);
`default_nettype wire

// File: tb/spm_pin_world.sv
// ======================================
// board model around the shared pins
// assumes pins packed as {d, c, b, a}
`timescale 1ns/1ps
`default_nettype none
module spm_pin_world (
	// clock
	input  wire logic        clk_in,
	// device side
	input  wire logic [25:0] drive_in,
	input  wire logic [25:0] oen_in,
	input  wire logic [25:0] pull_in,
	// board side
	input  wire logic [25:0] ext_in,
	input  wire logic [25:0] ext_en_in,
	output logic      [25:0] level_out
);
	logic [25:0] float_r = 26'h0;
	// a floating pin wanders so no read passes by luck
	always_ff @(posedge clk_in) begin
		float_r <= ~float_r;
	end
	// device drive first, then board, then pull-up
	assign level_out = (~oen_in & drive_in) | (oen_in & ext_en_in & ext_in)
		| (oen_in & ~ext_en_in & (pull_in | float_r));
endmodule
`default_nettype wire

// File: tb/spm_pin_mux_tb.sv
// ======================================
// testbench for the pin multiplexer and port registers
// assumes checker and pin model compiled first
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux_tb;
	// design ports
	logic        clk_in, resetn_in, clk_en_in, reg_wr_in, reg_rd_in;
	logic [3:0]  reg_addr_in, pin_c_in, pin_c_out, pin_c_oen_out, pull_c_out, sync_c_out;
	logic [7:0]  reg_wdata_in, reg_rdata_out, pin_b_in, pin_b_out, pin_b_oen_out, pull_b_out;
	logic [7:0]  pin_d_in, pin_d_out, pin_d_oen_out, pull_d_out, sync_b_out, sync_d_out;
	logic [5:0]  pin_a_in, pin_a_out, pin_a_oen_out, pull_a_out, keypad_en_in, sync_a_out;
	logic [9:0]  analog_sel_in;
	logic [1:0]  timer1_ch_en_in, timer1_hi_en_in, timer1_ch_out_in, timer1_ch_drive_in, timer1_hi_out_in;
	logic [1:0]  timer1_hi_drive_in, timer2_ch_en_in, timer2_ch_out_in, timer2_ch_drive_in;
	logic        timer1_ext_clock_en_in, irq_en_in, reset_pin_en_in, osc_in_en_in, xtal_out_en_in;
	logic        spi_en_in, spi_master_in, serial_rx_en_in, serial_tx_en_in, timer2_ext_clock_en_in;
	logic        timer2_channel_relocate_in, osc_clock_in, spi_clock_out_in, spi_mosi_out_in;
	logic        spi_miso_out_in, serial_tx_out_in;
	// board side and bookkeeping
	logic [25:0] ext_lvl, ext_en;
	wire  [25:0] lvl;
	logic [7:0]  d;
	int          err_count, compares;
	localparam logic [3:0] RA [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
	localparam logic [7:0] RM [8] = '{8'h3B, 8'hFF, 8'h07, 8'hFF, 8'h0F, 8'hFF, 8'hBF, 8'hFF};
	localparam logic [7:0] DZ [4] = '{8'h04, 8'h00, 8'h08, 8'h00};
	localparam logic [7:0] DF [4] = '{8'h3F, 8'hFF, 8'h0F, 8'hFF};
	// design and board
	spm_pin_mux i_spm_pin_mux (
		.clk_in, .resetn_in, .clk_en_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
		.reg_rdata_out, .pin_a_in, .pin_b_in, .pin_c_in, .pin_d_in, .pin_a_out, .pin_b_out,
		.pin_c_out, .pin_d_out, .pin_a_oen_out, .pin_b_oen_out, .pin_c_oen_out, .pin_d_oen_out,
		.pull_a_out, .pull_b_out, .pull_c_out, .pull_d_out, .analog_sel_in, .timer1_ch_en_in,
		.timer1_hi_en_in, .timer1_ext_clock_en_in, .keypad_en_in, .irq_en_in, .reset_pin_en_in,
		.osc_in_en_in, .xtal_out_en_in, .spi_en_in, .spi_master_in, .serial_rx_en_in,
		.serial_tx_en_in, .timer2_ch_en_in, .timer2_ext_clock_en_in, .timer2_channel_relocate_in,
		.timer1_ch_out_in, .timer1_ch_drive_in, .timer1_hi_out_in, .timer1_hi_drive_in,
		.osc_clock_in, .spi_clock_out_in, .spi_mosi_out_in, .spi_miso_out_in, .serial_tx_out_in,
		.timer2_ch_out_in, .timer2_ch_drive_in, .sync_a_out, .sync_b_out, .sync_c_out,
		.sync_d_out
	);
	spm_pin_world i_spm_pin_world (
		.clk_in,
		.drive_in({pin_d_out, pin_c_out, pin_b_out, pin_a_out}),
		.oen_in({pin_d_oen_out, pin_c_oen_out, pin_b_oen_out, pin_a_oen_out}),
		.pull_in({pull_d_out, pull_c_out, pull_b_out, pull_a_out}),
		.ext_in(ext_lvl),
		.ext_en_in(ext_en),
		.level_out(lvl)
	);
	assign {pin_d_in, pin_c_in, pin_b_in, pin_a_in} = lvl;
	// clocks
	always #12.5 clk_in = ~clk_in;
	always #50 osc_clock_in = ~osc_clock_in;
	// ======================================
	// helpers
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		tick(1);
		reg_wr_in = 1'b0;
		tick(1);
	endtask
	task rd(input logic [3:0] a);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		tick(1);
		reg_rd_in = 1'b0;
		tick(1);
		d = reg_rdata_out;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			err_count++;
			$display("Error at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	function automatic logic [15:0] pb();
		return {pin_b_oen_out, pin_b_out & ~pin_b_oen_out};
	endfunction
	function automatic logic [11:0] pa();
		return {pin_a_oen_out, pin_a_out & ~pin_a_oen_out};
	endfunction
	task periph_off;
		{analog_sel_in, timer1_ch_en_in, timer1_hi_en_in, timer1_ch_out_in, timer1_ch_drive_in,
			timer1_hi_out_in, timer1_hi_drive_in, timer2_ch_en_in, timer2_ch_out_in, timer2_ch_drive_in,
			timer1_ext_clock_en_in, irq_en_in, reset_pin_en_in, osc_in_en_in, xtal_out_en_in, spi_en_in,
			spi_master_in, serial_rx_en_in, serial_tx_en_in, timer2_ext_clock_en_in, keypad_en_in,
			timer2_channel_relocate_in, spi_clock_out_in, spi_mosi_out_in, spi_miso_out_in,
			serial_tx_out_in} = '0;
	endtask
	task do_reset;
		resetn_in = 1'b0;
		tick(16);
		resetn_in = 1'b1;
	endtask
	task finish_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ======================================
	// scenarios
	task t_regs;
		for (int i = 0; i < 8; i++) begin
			rd(RA[i]);
			check(d, 8'h00);
			wr(RA[i], 8'hFF);
			rd(RA[i]);
			check(d, RM[i]);
		end
		wr(4'hB, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(i[3:0], 8'h00);
			tick(6);
			rd(i[3:0]);
			check(d, DZ[i]);
			wr(i[3:0], 8'hFF);
			tick(6);
			rd(i[3:0]);
			check(d, DF[i]);
		end
		wr(4'h8, 8'hFF);
		rd(4'h8);
		check(d, 8'h00);
		clk_en_in = 1'b0;
		wr(4'h5, 8'h00);
		clk_en_in = 1'b1;
		rd(4'h5);
		check(d, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			wr(RA[i], 8'h00);
		end
	endtask
	task t_drive;
		wr(4'h7, 8'hFF);
		wr(4'h3, 8'h5A);
		check({pin_d_oen_out, pin_d_out}, 16'h005A);
		wr(4'hA, 8'hFF);
		wr(4'h7, 8'h0F);
		tick(6);
		check(pull_d_out, 8'hF0);
		rd(4'h3);
		check(d, 8'hFA);
		check(sync_d_out, 8'hFA);
		wr(4'hA, 8'h00);
		wr(4'hC, 8'hFF);
		check(pull_b_out, 8'hFF);
		wr(4'hC, 8'h00);
		wr(4'hB, 8'h3F);
		check(pull_a_out, 6'h3F);
		wr(4'hB, 8'h00);
		wr(4'h6, 8'h07);
		wr(4'h2, 8'h05);
		check({pin_c_oen_out, pin_c_out & ~pin_c_oen_out}, 8'h85);
		wr(4'h6, 8'h00);
	endtask
	task t_prio_a;
		wr(4'h4, 8'h2B);
		wr(4'h0, 8'h00);
		timer1_ch_en_in = 2'b01;
		timer1_ch_drive_in = 2'b01;
		timer1_ch_out_in = 2'b01;
		keypad_en_in = 6'h01;
		analog_sel_in = 10'h001;
		tick(3);
		check(pa(), {6'h14, 6'h01});
		timer1_ch_en_in = 2'b00;
		tick(3);
		check(pa(), {6'h15, 6'h00});
		keypad_en_in = 6'h10;
		irq_en_in = 1'b1;
		timer1_ext_clock_en_in = 1'b1;
		reset_pin_en_in = 1'b1;
		tick(3);
		check(pa(), {6'h1C, 6'h00});
		check(pin_a_oen_out[2], 1'b1);
		reset_pin_en_in = 1'b0;
		osc_in_en_in = 1'b1;
		xtal_out_en_in = 1'b1;
		tick(3);
		check(pin_a_oen_out, 6'h24);
		periph_off();
		wr(4'hB, 8'h80);
		check(pin_a_oen_out, 6'h04);
		wr(4'hB, 8'h00);
		analog_sel_in = 10'h002;
		wr(4'h4, 8'h00);
		tick(6);
		rd(4'h0);
		check(d, 8'h3F);
	endtask
	task t_prio_b;
		periph_off();
		wr(4'h5, 8'hFF);
		wr(4'h1, 8'h00);
		{spi_en_in, spi_master_in, spi_clock_out_in, spi_mosi_out_in} = 4'hF;
		timer2_ch_en_in = 2'b11;
		timer2_ch_drive_in = 2'b11;
		analog_sel_in = 10'h3FF;
		tick(3);
		check(pb(), 16'h0C03);
		spi_en_in = 1'b0;
		timer2_ch_out_in = 2'b11;
		tick(3);
		check(pb(), 16'h0006);
		timer2_ext_clock_en_in = 1'b1;
		tick(3);
		check(pb(), 16'h0806);
		timer2_channel_relocate_in = 1'b1;
		serial_tx_en_in = 1'b1;
		tick(3);
		check(pb(), 16'h0810);
		serial_rx_en_in = 1'b1;
		tick(3);
		check(pb(), 16'h1800);
		{spi_en_in, spi_master_in, spi_miso_out_in} = 3'b101;
		{timer1_hi_en_in, timer1_hi_drive_in, timer1_hi_out_in} = 6'h3F;
		tick(3);
		check(pb(), 16'h1BC4);
		periph_off();
		wr(4'h5, 8'h00);
	endtask
	task t_reset2;
		wr(4'h0, 8'h3F);
		wr(4'h4, 8'h3B);
		do_reset();
		rd(4'h4);
		check(d, 8'h00);
		wr(4'h4, 8'h3B);
		check(pa(), {6'h04, 6'h3B});
	endtask
	// ======================================
	// main sequence and watchdog
	initial begin
		periph_off();
		{clk_in, osc_clock_in, reg_wr_in, reg_rd_in} = 4'h0;
		clk_en_in = 1'b1;
		reg_addr_in = 4'h0;
		reg_wdata_in = 8'h00;
		ext_lvl = '1;
		ext_en = {8'h00, 18'h3FFFF};
		err_count = 0;
		compares = 0;
		do_reset();
		tick(3);
		check({pin_a_oen_out, pin_b_oen_out, pin_c_oen_out, pin_d_oen_out}, 26'h3FFFFFF);
		check({sync_a_out, sync_b_out, sync_c_out}, 18'h3FFFF);
		t_regs();
		t_drive();
		t_prio_a();
		t_prio_b();
		t_reset2();
		finish_test();
	end
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
endmodule
`default_nettype wire
